// file: srtc_pkg.sv
/*
 * shared constants of the single-wire seconds counter: command codes,
 * control byte layout, reset values and bus slot timing counts.
 * assumes a 10 MHz core clock; every count below is derived from it.
 */
package srtc_pkg;

    // core clock rate
    localparam int CLK_MHZ = 10;

    // identity layout
    localparam int ROM_BITS    = 64;
    localparam int FAMILY_BITS = 8;
    localparam int SERIAL_BITS = 48;
    localparam int CRC_BITS    = 8;
    localparam int CRC_SPAN    = FAMILY_BITS + SERIAL_BITS;
    // x^8 + x^5 + x^4 + 1, reflected for lsb-first shifting
    localparam logic [7:0] CRC_POLY_REFL = 8'h8C;

    // selection and clock function command codes
    localparam logic [7:0] CMD_READ_ID  = 8'h33;
    localparam logic [7:0] CMD_MATCH_ID = 8'h55;
    localparam logic [7:0] CMD_SKIP_ID  = 8'hCC;
    localparam logic [7:0] CMD_SEARCH   = 8'hF0;
    localparam logic [7:0] CMD_RD_CLOCK = 8'h66;
    localparam logic [7:0] CMD_WR_CLOCK = 8'h99;

    // control byte fields
    localparam int CTL_OSC_HI    = 3;
    localparam int CTL_OSC_LO    = 2;
    localparam int CTL_USER_LSB  = 4;
    localparam int CTL_USER_BITS = 4;
    localparam logic [1:0] CTL_ZERO_BITS = 2'h0;

    // reset values
    localparam logic                     OSC_RUN_RST = 1'b0;
    localparam logic [CTL_USER_BITS-1:0] USER_RST    = 4'h0;
    localparam logic [31:0]              SECS_RST    = 32'h0000_0000;

    // transfer shape: control byte plus four time bytes
    localparam int XFER_BYTES = 5;
    localparam logic [2:0] LAST_BYTE = 3'h4;

    // crystal prescaler: 32768 edges per second
    localparam int PRESC_BITS = 15;

    // bus timing in microseconds, then in core cycles
    localparam int RST_LOW_US  = 480;
    localparam int PDH_US      = 30;
    localparam int PDL_US      = 120;
    localparam int SAMPLE_US   = 30;
    localparam int ZERO_HOLD_US = 30;
    localparam int RST_LOW_CYC  = RST_LOW_US * CLK_MHZ;
    localparam int PDH_CYC      = PDH_US * CLK_MHZ;
    localparam int PDL_CYC      = PDL_US * CLK_MHZ;
    localparam int SAMPLE_CYC   = SAMPLE_US * CLK_MHZ;
    localparam int ZERO_HOLD_CYC = ZERO_HOLD_US * CLK_MHZ;
    localparam int TMR_BITS     = 13;

endpackage

// file: srtc_crc8.sv
/*
 * lsb-first crc over a fixed-width word, used to seal the identity code.
 * assumes a constant or slowly changing input; purely combinational.
 */
`timescale 1ns/1ps
`default_nettype none
module srtc_crc8 #(
    parameter int WIDTH = 56
) (
    // data in
    input  wire logic [WIDTH-1:0] data_in,
    // crc out
    output logic      [7:0]       crc_out
);
    import srtc_pkg::*;

    always_comb begin
        logic [7:0] c;
        logic       mix;
        c = 8'h00;
        mix = 1'b0;
        for (int i = 0; i < WIDTH; i++) begin
            mix = c[0] ^ data_in[i];
            c = {1'b0, c[7:1]};
            if (mix) begin
                c = c ^ CRC_POLY_REFL;
            end
        end
        crc_out = c;
    end

endmodule
`default_nettype wire

// file: srtc_wire_phy.sv
/*
 * slot timing of the single open-drain line: reset detection, presence
 * reply, per-slot sampling and holding the line low to send a zero.
 * assumes the line input is synchronous to the core clock.
 */
`timescale 1ns/1ps
`default_nettype none
module srtc_wire_phy #(
    parameter int RST_CYC = srtc_pkg::RST_LOW_CYC
) (
    // clock and reset
    input  wire logic core_clk_in,
    input  wire logic rst_n_in,
    // line
    input  wire logic line_in,
    output logic      pull_low_out,
    // protocol side
    input  wire logic send_zero_in,
    output logic      bit_done_out,
    output logic      bit_val_out,
    output logic      bus_reset_out
);
    import srtc_pkg::*;

    typedef enum logic [1:0] {P_IDLE, P_SLOT, P_PWAIT, P_PDRV} srtc_phase_t;

    localparam logic [TMR_BITS-1:0] T_RST  = TMR_BITS'(RST_CYC);
    localparam logic [TMR_BITS-1:0] T_SMP  = TMR_BITS'(SAMPLE_CYC);
    localparam logic [TMR_BITS-1:0] T_HOLD = TMR_BITS'(ZERO_HOLD_CYC);
    localparam logic [TMR_BITS-1:0] T_PDH  = TMR_BITS'(PDH_CYC);
    localparam logic [TMR_BITS-1:0] T_PDL  = TMR_BITS'(PDL_CYC);

    srtc_phase_t         ph_r, ph_nxt;
    logic [TMR_BITS-1:0] tmr_r, tmr_nxt;
    logic                prev_r, prev_nxt;
    logic                zero_r, zero_nxt;
    logic                drv_r, drv_nxt;
    logic                done_r, done_nxt;
    logic                val_r, val_nxt;
    logic                brst_r, brst_nxt;

    always_comb begin
        ph_nxt   = ph_r;
        tmr_nxt  = tmr_r;
        prev_nxt = line_in;
        zero_nxt = zero_r;
        drv_nxt  = 1'b0;
        done_nxt = 1'b0;
        val_nxt  = val_r;
        brst_nxt = 1'b0;
        case (ph_r)
            P_IDLE: begin
                // RULE22 slot starts on falling edge
                if (prev_r && !line_in) begin
                    ph_nxt   = P_SLOT;
                    tmr_nxt  = '0;
                    zero_nxt = send_zero_in;
                    drv_nxt  = send_zero_in;
                end
            end
            P_SLOT: begin
                if (tmr_r != T_RST) begin
                    tmr_nxt = tmr_r + 1'b1;
                end
                // RULE23 hold low past sampling point
                drv_nxt = zero_r && (tmr_nxt < T_HOLD);
                // RULE22 fixed-delay sample
                if (tmr_r == T_SMP) begin
                    val_nxt  = line_in;
                end
                if (tmr_r > T_SMP && line_in && !drv_r) begin
                    // RULE21 long low is a reset
                    if (tmr_r == T_RST) begin
                        ph_nxt   = P_PWAIT;
                        brst_nxt = 1'b1;
                    end else begin
                        // RULE16 bit counts only once slot ends
                        ph_nxt   = P_IDLE;
                        done_nxt = 1'b1;
                    end
                    tmr_nxt = '0;
                end
            end
            P_PWAIT: begin
                // RULE21 wait then presence low
                tmr_nxt = tmr_r + 1'b1;
                if (tmr_r == T_PDH) begin
                    ph_nxt  = P_PDRV;
                    tmr_nxt = '0;
                    drv_nxt = 1'b1;
                end
            end
            P_PDRV: begin
                tmr_nxt = tmr_r + 1'b1;
                drv_nxt = tmr_nxt < T_PDL;
                if (tmr_r == T_PDL) begin
                    ph_nxt  = P_IDLE;
                    tmr_nxt = '0;
                end
            end
            default: begin
                ph_nxt = P_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ph_r   <= P_IDLE;
            tmr_r  <= '0;
            prev_r <= 1'b1;
            zero_r <= 1'b0;
            drv_r  <= 1'b0;
            done_r <= 1'b0;
            val_r  <= 1'b1;
            brst_r <= 1'b0;
        end else begin
            ph_r   <= ph_nxt;
            tmr_r  <= tmr_nxt;
            prev_r <= prev_nxt;
            zero_r <= zero_nxt;
            drv_r  <= drv_nxt;
            done_r <= done_nxt;
            val_r  <= val_nxt;
            brst_r <= brst_nxt;
        end
    end

    assign pull_low_out  = drv_r;
    assign bit_done_out  = done_r;
    assign bit_val_out   = val_r;
    assign bus_reset_out = brst_r;

endmodule
`default_nettype wire

// file: srtc_top.sv
/*
 * single-wire seconds counter: identity code, selection commands, clock
 * read and write commands, control byte and crystal-driven counter.
 * assumes synchronous line and crystal inputs and a pull-up on the line.
 */
// What this block does
// RULE1 - holds 64-bit identity: family byte, 48-bit serial, crc byte
// RULE2 - identity crc uses x^8 + x^5 + x^4 + 1
// RULE3 - all bus bytes and fields travel least significant bit first
// RULE4 - clock commands only after a completed selection command
// RULE5 - oscillator switched by control flag; counter advances only running
// RULE6 - reads come from a snapshot buffer, not the live counter
// RULE7 - control bits 1,0 read zero; 3,2 oscillator flag; 7..4 user
// RULE8 - both oscillator flag bits read 1 running, 0 stopped
// RULE9 - on differing oscillator bits the value at bit 3 wins
// RULE10 - user flags have no effect, are read/write and kept
// RULE11 - counter is 32-bit seconds, increments once a second, wraps
// RULE12 - no random access: control byte first, then time lsb first
// RULE13 - last bit of read-clock command snapshots the counter
// RULE14 - read-clock sends control byte then four time bytes
// RULE15 - reading past fifth byte repeats the same five bytes
// RULE16 - bus reset ends a read anywhere with no side effects
// RULE17 - write-clock: control byte applies at once, time into buffer
// RULE18 - written time enters the counter on the next bus reset
// RULE19 - with oscillator stopped the counter holds as plain storage
// RULE20 - selection codes 33h, 55h, CCh, F0h; unmatched waits reset
// RULE21 - reset low 480 us; presence after 15-60 us, lasting 60-240 us
// RULE22 - slots start at falling edge; device samples after fixed delay
// RULE23 - zero sent by holding line low past 15 us sample point
// RULE24 - once-a-second tick divides crystal by 32768 while running
// RULE25 - any bus reset aborts and waits for a selection command
`timescale 1ns/1ps
`default_nettype none
module srtc_top #(
    parameter logic [7:0]  FAMILY_CODE = 8'hA5, // arbitrary value
    parameter logic [47:0] SERIAL_NUM  = 48'h0123_4567_89AB, // arbitrary
    parameter int          RST_CYC     = srtc_pkg::RST_LOW_CYC
) (
    // clock and reset
    input  wire logic core_clk_in,
    input  wire logic reset_n_in,
    // single-wire line, open drain
    input  wire logic line_in,
    output logic      line_out,
    output logic      line_oe_n_out,
    // crystal
    input  wire logic crystal_in,
    output logic      crystal_out
);
    import srtc_pkg::*;

    typedef enum logic [3:0] {
        ST_IDLE, ST_ROM_CMD, ST_READ_ROM, ST_MATCH, ST_SEARCH,
        ST_FN_CMD, ST_RD_CLK, ST_WR_CLK, ST_WAIT_RST
    } srtc_state_t;

    logic        rs1_r, rs2_r;
    logic        rst_n;
    logic [7:0]  crc;
    logic [63:0] rom;
    logic        pull_low, bit_done, bit_val, bus_rst;
    logic        send_zero;

    srtc_state_t st_r, st_nxt;
    logic [5:0]  cnt_r, cnt_nxt;
    logic [1:0]  phase_r, phase_nxt;
    logic [2:0]  byte_r, byte_nxt;
    logic [7:0]  sh_r, sh_nxt;
    logic        osc_r, osc_nxt;
    logic [3:0]  user_r, user_nxt;
    logic [31:0] buf_r, buf_nxt;
    logic        pend_r, pend_nxt;
    logic [31:0] secs_r, secs_nxt;
    logic [PRESC_BITS-1:0] presc_r, presc_nxt;
    logic        xprev_r, xprev_nxt;
    logic        xout_r, xout_nxt;

    logic [7:0]  ctl_byte;
    logic [7:0]  rd_byte;
    logic [7:0]  sh_in;
    logic        rom_bit;
    logic        tick;

    // reset release through two flops
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rs1_r <= 1'b0;
            rs2_r <= 1'b0;
        end else begin
            rs1_r <= 1'b1;
            rs2_r <= rs1_r;
        end
    end
    assign rst_n = rs2_r;

    // RULE2 crc over family and serial
    srtc_crc8 #(
        .WIDTH(CRC_SPAN)
    ) u_crc (
        .data_in({SERIAL_NUM, FAMILY_CODE}),
        .crc_out(crc)
    );
    // RULE1 identity layout, family first
    assign rom = {crc, SERIAL_NUM, FAMILY_CODE};

    srtc_wire_phy #(
        .RST_CYC(RST_CYC)
    ) u_phy (
        .core_clk_in  (core_clk_in),
        .rst_n_in     (rst_n),
        .line_in      (line_in),
        .pull_low_out (pull_low),
        .send_zero_in (send_zero),
        .bit_done_out (bit_done),
        .bit_val_out  (bit_val),
        .bus_reset_out(bus_rst)
    );

    assign line_out      = 1'b0;
    assign line_oe_n_out = ~pull_low;

    // RULE7 RULE8 control byte image
    assign ctl_byte = {user_r, osc_r, osc_r, CTL_ZERO_BITS};
    assign rom_bit  = rom[cnt_r];
    // RULE3 shift in lsb first
    assign sh_in    = {bit_val, sh_r[7:1]};

    // RULE14 byte order of a read
    always_comb begin
        case (byte_r)
            3'h0:    rd_byte = ctl_byte;
            3'h1:    rd_byte = buf_r[7:0];
            3'h2:    rd_byte = buf_r[15:8];
            3'h3:    rd_byte = buf_r[23:16];
            3'h4:    rd_byte = buf_r[31:24];
            default: rd_byte = ctl_byte;
        endcase
    end

    // RULE23 which slots pull the line low
    always_comb begin
        case (st_r)
            ST_READ_ROM: send_zero = !rom_bit;
            ST_SEARCH:   send_zero = (phase_r == 2'h0) ? !rom_bit :
                                     (phase_r == 2'h1) ? rom_bit : 1'b0;
            ST_RD_CLK:   send_zero = !rd_byte[cnt_r[2:0]];
            default:     send_zero = 1'b0;
        endcase
    end

    // protocol state
    always_comb begin
        st_nxt    = st_r;
        cnt_nxt   = cnt_r;
        phase_nxt = phase_r;
        byte_nxt  = byte_r;
        sh_nxt    = sh_r;
        osc_nxt   = osc_r;
        user_nxt  = user_r;
        buf_nxt   = buf_r;
        pend_nxt  = pend_r;
        if (bus_rst) begin
            // RULE25 RULE16 abort and restart selection
            st_nxt    = ST_ROM_CMD;
            cnt_nxt   = '0;
            phase_nxt = '0;
            byte_nxt  = '0;
            pend_nxt  = 1'b0;
        end else if (bit_done) begin
            cnt_nxt = cnt_r + 1'b1;
            case (st_r)
                ST_ROM_CMD: begin
                    sh_nxt = sh_in;
                    if (cnt_r == 6'd7) begin
                        cnt_nxt = '0;
                        // RULE20 selection command decode
                        case (sh_in)
                            CMD_READ_ID:  st_nxt = ST_READ_ROM;
                            CMD_MATCH_ID: st_nxt = ST_MATCH;
                            CMD_SEARCH:   st_nxt = ST_SEARCH;
                            CMD_SKIP_ID:  st_nxt = ST_FN_CMD;
                            default:      st_nxt = ST_WAIT_RST;
                        endcase
                    end
                end
                ST_READ_ROM: begin
                    if (cnt_r == 6'd63) begin
                        st_nxt = ST_FN_CMD;
                    end
                end
                ST_MATCH: begin
                    // RULE20 unmatched device waits for reset
                    if (bit_val != rom_bit) begin
                        st_nxt = ST_WAIT_RST;
                    end else if (cnt_r == 6'd63) begin
                        st_nxt = ST_FN_CMD;
                    end
                end
                ST_SEARCH: begin
                    cnt_nxt = cnt_r;
                    if (phase_r != 2'h2) begin
                        phase_nxt = phase_r + 1'b1;
                    end else if (bit_val != rom_bit) begin
                        st_nxt = ST_WAIT_RST;
                    end else begin
                        phase_nxt = '0;
                        cnt_nxt   = cnt_r + 1'b1;
                        if (cnt_r == 6'd63) begin
                            st_nxt = ST_FN_CMD;
                        end
                    end
                end
                ST_FN_CMD: begin
                    // RULE4 clock commands only reached from selection
                    sh_nxt = sh_in;
                    if (cnt_r == 6'd7) begin
                        cnt_nxt  = '0;
                        byte_nxt = '0;
                        if (sh_in == CMD_RD_CLOCK) begin
                            // RULE13 RULE6 snapshot on final bit
                            st_nxt  = ST_RD_CLK;
                            buf_nxt = secs_r;
                        end else if (sh_in == CMD_WR_CLOCK) begin
                            st_nxt = ST_WR_CLK;
                        end else begin
                            st_nxt = ST_WAIT_RST;
                        end
                    end
                end
                ST_RD_CLK: begin
                    if (cnt_r[2:0] == 3'h7) begin
                        cnt_nxt = '0;
                        // RULE15 RULE12 wrap back to control byte
                        byte_nxt = (byte_r == LAST_BYTE) ? 3'h0 :
                                   byte_r + 1'b1;
                    end
                end
                ST_WR_CLK: begin
                    sh_nxt = sh_in;
                    if (cnt_r[2:0] == 3'h7) begin
                        cnt_nxt  = '0;
                        byte_nxt = byte_r + 1'b1;
                        case (byte_r)
                            3'h0: begin
                                // RULE17 RULE9 control applies at once
                                osc_nxt  = sh_in[CTL_OSC_HI];
                                // RULE10 user flags stored only
                                user_nxt = sh_in[CTL_USER_LSB +:
                                                 CTL_USER_BITS];
                            end
                            3'h1: buf_nxt[7:0]   = sh_in;
                            3'h2: buf_nxt[15:8]  = sh_in;
                            3'h3: buf_nxt[23:16] = sh_in;
                            default: begin
                                buf_nxt[31:24] = sh_in;
                                pend_nxt       = 1'b1;
                                st_nxt         = ST_WAIT_RST;
                            end
                        endcase
                    end
                end
                default: begin
                    cnt_nxt = cnt_r;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            st_r    <= ST_IDLE;
            cnt_r   <= '0;
            phase_r <= '0;
            byte_r  <= '0;
            sh_r    <= '0;
            osc_r   <= OSC_RUN_RST;
            user_r  <= USER_RST;
            buf_r   <= SECS_RST;
            pend_r  <= 1'b0;
        end else begin
            st_r    <= st_nxt;
            cnt_r   <= cnt_nxt;
            phase_r <= phase_nxt;
            byte_r  <= byte_nxt;
            sh_r    <= sh_nxt;
            osc_r   <= osc_nxt;
            user_r  <= user_nxt;
            buf_r   <= buf_nxt;
            pend_r  <= pend_nxt;
        end
    end

    // timekeeping
    always_comb begin
        xprev_nxt = crystal_in;
        xout_nxt  = osc_r ? ~crystal_in : 1'b0;
        presc_nxt = presc_r;
        tick      = 1'b0;
        // RULE24 RULE5 prescaler runs only with oscillator on
        if (osc_r && crystal_in && !xprev_r) begin
            presc_nxt = presc_r + 1'b1;
            tick      = (presc_r == {PRESC_BITS{1'b1}});
        end
        // RULE11 RULE19 count seconds, wrap, hold when stopped
        secs_nxt = tick ? secs_r + 32'h0000_0001 : secs_r;
        // RULE18 written time loads on bus reset
        if (bus_rst && pend_r) begin
            secs_nxt = buf_r;
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            secs_r  <= SECS_RST;
            presc_r <= '0;
            xprev_r <= 1'b0;
            xout_r  <= 1'b0;
        end else begin
            secs_r  <= secs_nxt;
            presc_r <= presc_nxt;
            xprev_r <= xprev_nxt;
            xout_r  <= xout_nxt;
        end
    end

    assign crystal_out = xout_r;

endmodule
`default_nettype wire

// file: srtc_master_model.sv
/*
 * bus master model: reset pulses, write slots and read slots.
 * assumes line_in is the resolved wire level with a pull-up.
 */
`timescale 1ns/1ps
`default_nettype none
module srtc_master_model #(
    parameter int RST_CYC = 4800
) (
    // clock
    input  wire logic core_clk_in,
    // line
    input  wire logic line_in,
    output var logic  pull_out
);
    initial pull_out = 1'b0;
    task automatic hold(input int n, input logic low);
        pull_out <= low;
        repeat (n) @(posedge core_clk_in);
    endtask
    task automatic bus_reset(output logic pres);
        hold(RST_CYC + 80, 1'b1);
        hold(450, 1'b0);
        pres = !line_in;
        hold(1100, 1'b0);
    endtask
    task automatic write_bit(input logic b);
        hold(b ? 50 : 600, 1'b1);
        hold(b ? 570 : 20, 1'b0);
    endtask
    task automatic read_bit(output logic b);
        hold(20, 1'b1);
        hold(130, 1'b0);
        b = line_in;
        hold(470, 1'b0);
    endtask
    task automatic write_byte(input logic [7:0] v);
        for (int i = 0; i < 8; i++) write_bit(v[i]);
    endtask
    task automatic read_byte(output logic [7:0] v);
        for (int i = 0; i < 8; i++) read_bit(v[i]);
    endtask
endmodule
`default_nettype wire

// file: srtc_top_checker.sv
/*
 * pin assertions for srtc_top.
 * assumes line_in is the resolved wire level; bound from the bench.
 */
`timescale 1ns/1ps
`default_nettype none
module srtc_top_checker #(
    parameter int RST_CYC = 4800
) (
    // pins of srtc_top
    input wire logic core_clk_in,
    input wire logic reset_n_in,
    input wire logic line_in,
    input wire logic line_out,
    input wire logic line_oe_n_out,
    input wire logic crystal_in,
    input wire logic crystal_out
);
    logic [15:0] low_r, low_nxt, pull_r, pull_nxt;
    logic        seen_r, seen_nxt, pres_r, pres_nxt;
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!reset_n_in);
    // master low time, device pull time
    always_comb begin
        low_nxt = low_r + {15'h0000, ~&low_r};
        if (line_in || !line_oe_n_out) low_nxt = 16'h0000;
        pull_nxt = line_oe_n_out ? 16'h0000 : pull_r + 16'h0001;
        seen_nxt = seen_r || (low_r >= 16'(RST_CYC));
        pres_nxt = line_oe_n_out ? line_in : pres_r;
    end
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            {low_r, pull_r, seen_r, pres_r} <= 34'h0;
        end else begin
            {low_r, pull_r} <= {low_nxt, pull_nxt};
            {seen_r, pres_r} <= {seen_nxt, pres_nxt};
        end
    end
    sequence s_wait;
        line_oe_n_out throughout (##150 1'b1);
    endsequence
    sequence s_pull;
        ##[0:450] $fell(line_oe_n_out);
    endsequence
    pres_gap_a: assert property (
        $rose(line_in) && low_r >= 16'(RST_CYC) |-> s_wait ##0 s_pull)
        else $error("presence not 15-60 us after reset");
    pres_len_a: assert property (
        $rose(line_oe_n_out) && pres_r |-> pull_r inside {[600:2400]})
        else $error("presence length off");
    zero_len_a: assert property (
        $rose(line_oe_n_out) && !pres_r |-> pull_r inside {[150:600]})
        else $error("zero hold length off");
    rst_clear_a: assert property (
        low_r == 16'(RST_CYC) |-> line_oe_n_out)
        else $error("device pulls during bus reset");
    idle_quiet_a: assert property (!seen_r |-> line_oe_n_out)
        else $error("pull before any bus reset");
    drain_zero_a: assert property (!line_out)
        else $error("line data not low");
    xtal_inv_a: assert property (crystal_out |-> !$past(crystal_in))
        else $error("crystal drive not inverse");
    rel_quiet_a: assert property (
        $rose(reset_n_in) |-> (line_oe_n_out && !crystal_out)[*3])
        else $error("activity during reset release");
endmodule
`default_nettype wire

// file: srtc_top_bench.sv
/*
 * bench for srtc_top: master model, crystal driver, byte model.
 * assumes srtc_pkg, the master model and the checker are compiled.
 */
`timescale 1ns/1ps
`default_nettype none
module srtc_top_bench;
    import srtc_pkg::*;
    localparam int RST = 800;
    localparam logic [7:0] FAM = 8'hA5; // arbitrary value
    logic core_clk_in, reset_n_in, crystal_in, m_pull, p;
    logic line_out, line_oe_n_out, crystal_out;
    wire line_w;
    int fails, checks, cyc, xtal_left;
    logic [7:0] m_ctl;
    logic [31:0] m_secs;
    assign line_w = m_pull ? 1'b0 : (line_oe_n_out ? 1'b1 : line_out);
    srtc_top #(.FAMILY_CODE(FAM), .RST_CYC(RST)) srtc_top_i (
        .core_clk_in(core_clk_in), .reset_n_in(reset_n_in),
        .line_in(line_w), .line_out(line_out),
        .line_oe_n_out(line_oe_n_out), .crystal_in(crystal_in),
        .crystal_out(crystal_out));
    srtc_master_model #(.RST_CYC(RST)) srtc_master_model_i (
        .core_clk_in(core_clk_in), .line_in(line_w), .pull_out(m_pull));
    always #50 core_clk_in = ~core_clk_in;
    // crystal edges on demand, and the hang limit
    always @(posedge core_clk_in) begin
        cyc <= cyc + 1;
        if (xtal_left > 0) begin
            crystal_in <= ~crystal_in;
            if (!crystal_in) xtal_left <= xtal_left - 1;
        end
        if (cyc == 180000) begin
            fails++;
            complete_run();
        end
    end
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("Error %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic chk_pres(input logic got);
        checks++;
        if (got !== 1'b1) begin
            fails++;
            $display("Error %0t: no presence", $time);
        end
    endtask
    task automatic pre(input logic [7:0] c);
        srtc_master_model_i.bus_reset(p);
        chk_pres(p);
        srtc_master_model_i.write_byte(c);
    endtask
    task automatic read_clock(input int n);
        logic [7:0] v;
        logic [7:0] e;
        pre(CMD_SKIP_ID);
        srtc_master_model_i.write_byte(CMD_RD_CLOCK);
        for (int k = 0; k < n; k++) begin
            e = (k % 5 == 0) ? m_ctl : 8'(m_secs >> (8 * (k % 5 - 1)));
            srtc_master_model_i.read_byte(v);
            chk_byte(v, e);
        end
    endtask
    task automatic complete_run();
        $display("fails %0d checks %0d", fails, checks);
        if (fails == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        logic [7:0] v;
        logic [31:0] r;
        logic b0;
        logic b1;
        core_clk_in = 1'b0;
        reset_n_in = 1'b0;
        crystal_in = 1'b0;
        fails = 0;
        checks = 0;
        cyc = 0;
        xtal_left = 0;
        void'($urandom(41));
        r = $urandom();
        m_ctl = {r[7:4], 4'hC};
        m_secs = 32'hFFFF_FFFF;
        repeat (3) @(posedge core_clk_in);
        reset_n_in <= 1'b1;
        repeat (3) @(posedge core_clk_in);
        pre(CMD_SKIP_ID);
        srtc_master_model_i.write_byte(CMD_WR_CLOCK);
        srtc_master_model_i.write_byte({r[7:4], 2'h2, r[1:0]});
        xtal_left <= 32768;
        for (int i = 0; i < 4; i++) srtc_master_model_i.write_byte(8'hFF);
        read_clock(6);
        pre(CMD_READ_ID);
        srtc_master_model_i.read_byte(v);
        chk_byte(v, FAM);
        pre(CMD_SEARCH);
        srtc_master_model_i.read_bit(b0);
        srtc_master_model_i.read_bit(b1);
        chk_byte({6'h00, b1, b0}, {6'h00, ~FAM[0], FAM[0]});
        while (xtal_left != 0) @(posedge core_clk_in);
        m_secs = m_secs + 32'h0000_0001;
        read_clock(5);
        for (int i = 0; i < 3; i++) srtc_master_model_i.read_bit(b0);
        pre(CMD_RD_CLOCK);
        srtc_master_model_i.read_byte(v);
        chk_byte(v, 8'hFF);
        complete_run();
    end
endmodule
bind srtc_top srtc_top_checker #(.RST_CYC(RST_CYC)) srtc_top_checker_i (
    .core_clk_in(core_clk_in), .reset_n_in(reset_n_in),
    .line_in(line_in), .line_out(line_out),
    .line_oe_n_out(line_oe_n_out), .crystal_in(crystal_in),
    .crystal_out(crystal_out));
`default_nettype wire
